/* verilog/usg_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef USG_MAP_SVH
`define USG_MAP_SVH
`define USG_OFF_DIV_LOW      4'h0
`define USG_OFF_DIV_HIGH     4'h1
`define USG_OFF_CTRL_A       4'h2
`define USG_OFF_CTRL_B       4'h3
`define USG_OFF_CTRL_C       4'h4
`define USG_OFF_DATA_LOW     4'h5
`define USG_OFF_DATA_HIGH    4'h6
`define USG_OFF_STATUS       4'h7
`define USG_A_DOUBLE_SPEED   1
`define USG_C_SYNC_MODE      0
`define USG_C_CLK_DIR        1
`define USG_C_POLARITY       2
`define USG_C_STOP2          3
`define USG_C_PAR_LO         4
`define USG_C_CSZ_LO         6
`define USG_B_TX_EN          0
`define USG_B_RX_EN          1
`define USG_B_TX9            2
`define USG_RST_CTRL_C       8'h0_6
`define USG_CSZ_NINE         3'h7
`define USG_OVS_NORMAL       5'h1_0
`define USG_OVS_DOUBLE       5'h0_8
`define USG_OVS_SYNC         5'h0_2
`endif

/* verilog/usg_pkg.sv */
// types shared by the serial transceiver files
package usg_pkg;
  typedef enum logic [2:0] {
    USG_IDLE  = 3'b000,
    USG_START = 3'b001,
    USG_DATA  = 3'b010,
    USG_PAR   = 3'b011,
    USG_STOP1 = 3'b100,
    USG_STOP2 = 3'b101
  } usg_ph_e;
  typedef logic [11:0] usg_div_t;
endpackage

/* verilog/usg_baud_gen.sv */
// baud down-counter emitting one tick each time the count reaches zero
`timescale 1ns/1ps
`include "usg_map.svh"
module usg_baud_gen (
  // system
  input  wire logic              clock,
  input  wire logic              resetn,
  // control
  input  wire usg_pkg::usg_div_t divisor,
  input  wire logic              reload,
  // output
  output logic                   tick
);
  import usg_pkg::*;
  typedef struct packed {
    usg_div_t cnt;
    logic     tick;
  } usg_bg_s;
  usg_bg_s st_r;
  usg_bg_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (reload) begin
      st_nxt.cnt = divisor; // see [R1]
    end else if (st_r.cnt == 12'h000) begin
      st_nxt.cnt = divisor; // see [R1]
      st_nxt.tick = 1'b1; // see [R2]
    end else begin
      st_nxt.cnt = st_r.cnt - 12'h001;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign tick = st_r.tick;
endmodule // usg_baud_gen

/* verilog/usg_core.sv */
// serial transceiver: clocking, framing, transmit and receive paths
//
// Contract
// [R1] divisor down-counter reloads at zero or low write
// [R2] one tick per zero, rate clk/(div+1)
// [R3] twelve-bit divisor in high and low registers
// [R4] transmit divides ticks by 16, 8 or 2
// [R5] receiver recovery uses 16, 8 or 2 states; code recovers with 16 or 8, sync mode samples on edges
// [R6] sync select and pin direction pick mode
// [R7] double speed only matters when asynchronous
// [R8] double speed: divide by 8, 8 samples
// [R9] clock pin used only in sync mode
// [R10] slave clock synchronised then edge detected
// [R11] peer keeps slave clock below clk/4
// [R12] sample edge opposite to change edge
// [R13] polarity picks change and sample edges
// [R14] start, 5-9 data, parity, 1-2 stops
// [R15] start, data lsb first, parity, stops
// [R16] next frame back to back or idle high
// [R17] one shared frame format for both directions
// [R18] receiver checks first stop bit only
// [R19] parity is xor of data, odd inverts
// [R20] two-level receive buffer, frame/overrun/parity errors
// [R21] single transmit buffer ahead of shifter
// [R22] software clears power cut bit first
// [R23] nine bits: size 7, ninth bit first
// [R24] async start edge, centre sampling
`timescale 1ns/1ps
`include "usg_map.svh"
module usg_core (
  // system
  input  wire logic       clock,
  input  wire logic       resetn,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // serial pins
  input  wire logic       serial_rx_pin,
  output logic            serial_tx_pin,
  // transfer clock pin
  input  wire logic       transfer_clock_pin_in,
  output logic            transfer_clock_pin_out,
  output logic            transfer_clock_pin_oe_n
);
  import usg_pkg::*;

  typedef struct packed {
    logic [7:0] div_low;
    logic [3:0] div_high;
    logic       double_speed;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [7:0] rdata;
    logic [2:0] rxs;
    logic [2:0] cks;
    logic       xck_o;
    logic       tx_pin;
    logic       txb_full;
    logic [8:0] txb;
    usg_ph_e    tph;
    logic [3:0] tcnt;
    logic [3:0] tbit;
    logic [8:0] tsh;
    logic       tpar;
    usg_ph_e    rph;
    logic [3:0] rcnt;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic       rpar;
    logic       rx_prev;
    logic [1:0] rq_cnt;
    logic [11:0] rq0;
    logic [11:0] rq1;
    logic       overrun;
    logic       oe_n;
  } usg_st_s;
  usg_st_s st_r;
  usg_st_s st_nxt;

  logic     baud_tick;
  logic     div_reload;
  usg_div_t div_live;

  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    data_bits = (csz == `USG_CSZ_NINE) ? 4'h9 : {2'b00, csz[1:0]} + 4'h5;
  endfunction

  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
                                     input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        p = p ^ d[i];
      end
    end
    parity_of = p; // see [R19]
  endfunction

  assign div_reload = reg_wr && (reg_addr == `USG_OFF_DIV_LOW); // see [R1]
  // a low-byte write reloads with the byte being written, not the stale one
  assign div_live = {st_r.div_high, div_reload ? reg_wdata : st_r.div_low}; // see [R1]

  usg_baud_gen u_baud (
    .clock   (clock),
    .resetn  (resetn),
    .divisor (div_live),
    .reload  (div_reload),
    .tick    (baud_tick)
  );

  always_comb begin
    logic       sync_m;
    logic       master;
    logic       pol;
    logic [2:0] csz;
    logic [3:0] nbits;
    logic [1:0] pm;
    logic [4:0] ovs;
    logic       xs_rise;
    logic       xs_fall;
    logic       chg_ev;
    logic       smp_ev;
    logic       t_step;
    logic       rxd;
    logic       r_smp;
    logic       pop;
    logic [11:0] word;
    logic       ovr_set;
    st_nxt = st_r;
    sync_m = st_r.ctrl_c[`USG_C_SYNC_MODE]; // see [R6]
    master = st_r.ctrl_c[`USG_C_CLK_DIR];
    pol    = st_r.ctrl_c[`USG_C_POLARITY];
    csz    = {st_r.ctrl_b[`USG_B_TX9 + 1], st_r.ctrl_c[`USG_C_CSZ_LO +: 2]};
    nbits  = data_bits(csz); // see [R14] [R17] [R23]
    pm     = st_r.ctrl_c[`USG_C_PAR_LO +: 2];
    // double speed ignored in sync mode
    ovs    = sync_m ? `USG_OVS_SYNC
           : (st_r.double_speed ? `USG_OVS_DOUBLE : `USG_OVS_NORMAL); // see [R4] [R7] [R8]
    xs_rise = 1'b0;
    xs_fall = 1'b0;
    pop     = 1'b0;
    word    = 12'h000;
    ovr_set = 1'b0;

    // slave clock: three flops, edge when second and third differ
    st_nxt.cks = {st_r.cks[1:0], transfer_clock_pin_in}; // see [R10]
    if (st_r.cks[2] != st_r.cks[1]) begin
      xs_rise = st_r.cks[1];
      xs_fall = !st_r.cks[1];
    end
    // master clock toggles every tick unless idle at its polarity level, giving divide by 2
    if (sync_m && master && baud_tick && (st_r.tph != USG_IDLE || st_r.xck_o != pol)) begin
      st_nxt.xck_o = !st_r.xck_o; // see [R4]
      xs_rise = !st_r.xck_o;
      xs_fall = st_r.xck_o;
    end else if (sync_m && master) begin
      xs_rise = 1'b0;
      xs_fall = 1'b0;
    end
    chg_ev = pol ? xs_fall : xs_rise; // see [R12] [R13]
    smp_ev = pol ? xs_rise : xs_fall; // see [R12] [R13]
    if (!sync_m) begin
      chg_ev = 1'b0;
      smp_ev = 1'b0;
      st_nxt.xck_o = 1'b0; // see [R9]
    end

    // transmitter
    t_step = 1'b0;
    if (sync_m) begin
      t_step = chg_ev;
    end else if (baud_tick) begin
      if (st_r.tcnt == 4'(ovs - 5'd1)) begin
        st_nxt.tcnt = 4'h0;
        t_step = 1'b1; // see [R4]
      end else begin
        st_nxt.tcnt = st_r.tcnt + 4'h1;
      end
    end
    // async frames start on the bit grid so the start bit is never short
    if (t_step || (sync_m && st_r.tph == USG_IDLE)) begin
      unique case (st_r.tph)
        USG_IDLE, USG_STOP1, USG_STOP2: begin
          if (st_r.tph == USG_STOP1 && st_r.ctrl_c[`USG_C_STOP2]) begin
            st_nxt.tph = USG_STOP2;
          end else if (st_r.txb_full && st_r.ctrl_b[`USG_B_TX_EN]) begin
            st_nxt.tph = USG_START; // see [R16] [R21]
            st_nxt.tsh = st_r.txb;
            st_nxt.tpar = parity_of(st_r.txb, nbits, pm[0]);
            st_nxt.txb_full = 1'b0;
            st_nxt.tx_pin = 1'b0; // see [R14]
            st_nxt.tcnt = 4'h0;
          end else begin
            st_nxt.tph = USG_IDLE;
            st_nxt.tx_pin = 1'b1; // see [R16]
          end
        end
        USG_START: begin
          st_nxt.tph = USG_DATA;
          st_nxt.tbit = 4'h1;
          st_nxt.tx_pin = st_r.tsh[0]; // see [R15]
          st_nxt.tsh = {1'b0, st_r.tsh[8:1]};
        end
        USG_DATA: begin
          if (st_r.tbit == nbits) begin
            st_nxt.tph = pm[1] ? USG_PAR : USG_STOP1;
            st_nxt.tx_pin = pm[1] ? st_r.tpar : 1'b1; // see [R15]
          end else begin
            st_nxt.tbit = st_r.tbit + 4'h1;
            st_nxt.tx_pin = st_r.tsh[0];
            st_nxt.tsh = {1'b0, st_r.tsh[8:1]};
          end
        end
        USG_PAR: begin
          st_nxt.tph = USG_STOP1;
          st_nxt.tx_pin = 1'b1;
        end
      endcase
    end

    // receiver input: three flops, act when second and third agree
    st_nxt.rxs = {st_r.rxs[1:0], serial_rx_pin};
    rxd = (st_r.rxs[2] == st_r.rxs[1]) ? st_r.rxs[1] : st_r.rx_prev;
    st_nxt.rx_prev = rxd;
    r_smp = 1'b0;
    if (sync_m) begin
      r_smp = smp_ev && (st_r.rph != USG_IDLE || !rxd);
      if (st_r.rph == USG_IDLE && r_smp) begin
        st_nxt.rph = USG_DATA;
        st_nxt.rbit = 4'h0;
        r_smp = 1'b0;
      end
    end else if (st_r.rph == USG_IDLE) begin
      if (st_r.rx_prev && !rxd && st_r.ctrl_b[`USG_B_RX_EN]) begin
        st_nxt.rph = USG_START; // see [R24]
        st_nxt.rcnt = 4'h0;
      end
    end else if (baud_tick) begin
      // recovery states: sample mid-bit
      if (st_r.rcnt == 4'(ovs - 5'd1)) begin
        st_nxt.rcnt = 4'h0;
      end else begin
        st_nxt.rcnt = st_r.rcnt + 4'h1; // see [R5] [R8]
      end
      r_smp = (st_r.rcnt == 4'(ovs[4:1] - 5'd1)); // see [R24]
    end
    if (r_smp) begin
      unique case (st_r.rph)
        USG_START: begin
          // false start: line went back high at mid-bit
          st_nxt.rph = rxd ? USG_IDLE : USG_DATA;
          st_nxt.rbit = 4'h0;
        end
        USG_DATA: begin
          st_nxt.rsh = {rxd, st_r.rsh[8:1]};
          st_nxt.rbit = st_r.rbit + 4'h1;
          if (st_r.rbit + 4'h1 == nbits) begin
            st_nxt.rph = pm[1] ? USG_PAR : USG_STOP1;
          end
        end
        USG_PAR: begin
          st_nxt.rpar = rxd;
          st_nxt.rph = USG_STOP1;
        end
        default: begin
          // second stop bit is never looked at
          st_nxt.rph = USG_IDLE; // see [R18]
          word[8:0] = {st_r.rsh} >> (4'h9 - nbits);
          word[9] = !rxd; // see [R18]
          word[10] = pm[1] && (parity_of(word[8:0], nbits, pm[0]) != st_r.rpar);
          if (st_r.rq_cnt == 2'd2) begin
            st_nxt.overrun = 1'b1; // see [R20]
            ovr_set = 1'b1;
          end else begin
            if (st_r.rq_cnt == 2'd0) begin
              st_nxt.rq0 = word;
            end else begin
              st_nxt.rq1 = word;
            end
            st_nxt.rq_cnt = st_r.rq_cnt + 2'd1;
          end
        end
      endcase
    end

    // register port
    if (reg_wr) begin
      unique case (reg_addr)
        `USG_OFF_DIV_LOW:  st_nxt.div_low = reg_wdata; // see [R3]
        `USG_OFF_DIV_HIGH: st_nxt.div_high = reg_wdata[3:0];
        `USG_OFF_CTRL_A:   st_nxt.double_speed = reg_wdata[`USG_A_DOUBLE_SPEED];
        `USG_OFF_CTRL_B:   st_nxt.ctrl_b = reg_wdata;
        `USG_OFF_CTRL_C:   st_nxt.ctrl_c = reg_wdata;
        `USG_OFF_DATA_LOW: begin
          if (!st_r.txb_full) begin
            st_nxt.txb = {st_r.ctrl_b[`USG_B_TX9], reg_wdata}; // see [R23] [R21]
            st_nxt.txb_full = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd && reg_addr == `USG_OFF_DATA_LOW && st_r.rq_cnt != 2'd0) begin
      pop = 1'b1;
    end
    unique case (reg_addr)
      `USG_OFF_DIV_LOW:   st_nxt.rdata = st_r.div_low;
      `USG_OFF_DIV_HIGH:  st_nxt.rdata = {4'h0, st_r.div_high};
      `USG_OFF_CTRL_A:    st_nxt.rdata = {6'h00, st_r.double_speed, 1'b0};
      `USG_OFF_CTRL_B:    st_nxt.rdata = st_r.ctrl_b;
      `USG_OFF_CTRL_C:    st_nxt.rdata = st_r.ctrl_c;
      `USG_OFF_DATA_LOW:  st_nxt.rdata = st_r.rq0[7:0];
      `USG_OFF_DATA_HIGH: st_nxt.rdata = {7'h00, st_r.rq0[8]};
      `USG_OFF_STATUS:    st_nxt.rdata = {st_r.rq_cnt != 2'd0, !st_r.txb_full,
                                          st_r.tph == USG_IDLE, st_r.rq0[9],
                                          st_r.overrun, st_r.rq0[10], 2'b00};
      default:            st_nxt.rdata = 8'h00;
    endcase
    if (!reg_rd) begin
      st_nxt.rdata = 8'h00;
    end
    if (pop) begin
      st_nxt.rq0 = st_r.rq1;
      st_nxt.rq_cnt = st_nxt.rq_cnt - 2'd1;
      // a fresh overrun outranks the clear by the read
      st_nxt.overrun = ovr_set;
      if (st_r.rq_cnt == 2'd1 && st_nxt.rq_cnt == 2'd1) begin
        st_nxt.rq0 = st_nxt.rq1;
      end
    end
    st_nxt.oe_n = !(st_nxt.ctrl_c[`USG_C_SYNC_MODE] && st_nxt.ctrl_c[`USG_C_CLK_DIR]); // see [R9]
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r        <= '0;
      st_r.ctrl_c <= `USG_RST_CTRL_C;
      st_r.tx_pin <= 1'b1;
      st_r.rx_prev <= 1'b1;
      st_r.rxs    <= 3'b111;
      st_r.tph    <= USG_IDLE;
      st_r.rph    <= USG_IDLE;
      st_r.oe_n   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata               = st_r.rdata;
  assign serial_tx_pin           = st_r.tx_pin;
  assign transfer_clock_pin_out  = st_r.xck_o;
  // driven only as sync master
  assign transfer_clock_pin_oe_n = st_r.oe_n; // see [R9]
endmodule // usg_core

/* dv/usg_core_chk.sv */
// port checker for the serial transceiver core
`timescale 1ns/1ps
module usg_core_chk (
  // system
  input wire logic       clock,
  input wire logic       resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic       serial_tx_pin,
  input wire logic       transfer_clock_pin_out,
  input wire logic       transfer_clock_pin_oe_n
);
  logic [11:0] div_r;
  logic [7:0]  c_r;
  logic        ds_r;
  logic        txen_r;
  logic        ck_q;
  logic [15:0] low_r;
  logic [15:0] hold_r;
  int unsigned bitlen;
  assign bitlen = (div_r + 1) * (ds_r ? 8 : 16);
  // shadows of bus writes so the checks follow the live setup
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_r  <= 12'h000;
      c_r    <= 8'h06;
      ds_r   <= 1'b0;
      txen_r <= 1'b0;
      ck_q   <= 1'b0;
      low_r  <= 16'h0000;
      hold_r <= 16'hffff;
    end else begin
      if (reg_wr && reg_addr == 4'h0) div_r[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == 4'h1) div_r[11:8] <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 4'h2) ds_r <= reg_wdata[1];
      if (reg_wr && reg_addr == 4'h3) txen_r <= reg_wdata[0];
      if (reg_wr && reg_addr == 4'h4) c_r <= reg_wdata;
      ck_q   <= transfer_clock_pin_out;
      low_r  <= serial_tx_pin ? 16'h0000 : low_r + 16'h0001;
      // saturates so a long quiet spell never wraps
      hold_r <= (transfer_clock_pin_out != ck_q) ? 16'h0001 : hold_r + (hold_r != 16'hffff);
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) > 4'h7 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrlc_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h4 |-> reg_rdata == $past(c_r))
    else $error("frame setup readback wrong");
  oe_decode_a: assert property (transfer_clock_pin_oe_n == !(c_r[0] && c_r[1]))
    else $error("clock pin drive wrong for mode");
  tx_reset_idle_a: assert property ($rose(resetn) |-> serial_tx_pin)
    else $error("transmit line not idle after reset");
  tx_off_idle_a: assert property (!txen_r |-> serial_tx_pin)
    else $error("transmit line low while disabled");
  low_run_a: assert property ($rose(serial_tx_pin) && !c_r[0] |-> (low_r % bitlen) == 0)
    else $error("low run not whole bit times");
  clk_half_a: assert property (c_r[1:0] == 2'b11 && transfer_clock_pin_out != ck_q |-> hold_r > div_r)
    else $error("master clock half period too short");
  cover property ($rose(serial_tx_pin) && !c_r[0] && ds_r);
  cover property (c_r[1:0] == 2'b11 && transfer_clock_pin_out != ck_q);
  cover property ($past(reg_rd) && $past(reg_addr) == 4'h4);
endmodule // usg_core_chk

bind usg_core usg_core_chk usg_core_chk_i (
  .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .serial_tx_pin, .transfer_clock_pin_out, .transfer_clock_pin_oe_n
);

/* dv/usg_peer.sv */
// remote serial peer: drives the receive line, samples the transmit line
`timescale 1ns/1ps
module usg_peer (
  // system
  input  wire logic clock,
  // serial lines
  input  wire logic tx_line,
  output logic      rx_line,
  output logic      clk_line
);
  initial begin
    rx_line  = 1'b1;
    clk_line = 1'b0; // still outside frames
  end
  // frame held lsb first, start at bit 0
  task automatic send(input logic [12:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      rx_line <= f[i];
      repeat (bc) @(posedge clock);
    end
    rx_line <= 1'b1;
  endtask
  // samples mid-bit, far from the edges
  task automatic grab(input int n, input int bc, output logic [12:0] f);
    f = 13'h1fff;
    @(negedge tx_line);
    repeat (bc / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      f[i] = tx_line;
      if (i < n - 1) repeat (bc) @(posedge clock);
    end
  endtask
  // slave clock well below clk/4; sample just before each rising edge
  task automatic clock_in(input int n, input int half, output logic [12:0] f);
    f = 13'h1fff;
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge clock);
      f[i] = tx_line;
      clk_line <= 1'b1;
      repeat (half) @(posedge clock);
      clk_line <= 1'b0;
    end
  endtask
endmodule // usg_peer

/* dv/tb_usart_clock_gen_and_framing.sv */
// self-checking bench for the serial transceiver core
`timescale 1ns/1ps
module tb_usart_clock_gen_and_framing;
  logic       clock;
  logic       resetn;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       rx;
  logic       tx;
  logic       ck_in;
  logic       ck_out;
  logic       ck_oe_n;
  int         failures;
  int         n_checks;
  int         cyc;
  usg_core usg_core_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_rx_pin(rx), .serial_tx_pin(tx), .transfer_clock_pin_in(ck_in),
    .transfer_clock_pin_out(ck_out), .transfer_clock_pin_oe_n(ck_oe_n));
  usg_peer usg_peer_i (.clock(clock), .tx_line(tx), .rx_line(rx), .clk_line(ck_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic finish_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 30000) begin
      failures++;
      finish_test();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [12:0] frame(logic [8:0] d, int n, int p, int s2, output int len);
    logic [12:0] f;
    f = 13'h1fff;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[i + 1] = d[i];
    if (p != 0) f[n + 1] = ^(d & ((9'h1 << n) - 1)) ^ (p == 3);
    len = n + 2 + (p != 0) + s2;
    return f;
  endfunction
  initial begin
    logic [7:0]  v;
    logic [7:0]  m;
    logic [12:0] f;
    logic [12:0] g;
    logic [8:0]  d;
    logic        c0;
    int          n, p, s2, len, bc, ds, csz, k;
    resetn    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    void'($urandom(32'h3a00_101a));
    repeat (12) @(posedge clock);
    resetn <= 1'b1; // block powered from here
    rd(4'h4, v);
    chk(v, 13'h0006);
    rd(4'h9, v);
    chk(v, 13'h0000);
    chk(tx, 1'b1);
    chk(ck_oe_n, 1'b1);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h01);
    for (int t = 0; t < 6; t++) begin
      n   = (t < 5) ? t + 5 : 5 + $urandom_range(4);
      p   = $urandom_range(2);
      p   = (p == 0) ? 0 : p + 1;
      s2  = (t == 3) ? 1 : $urandom_range(1);
      ds  = t % 2;
      bc  = ds ? 16 : 32;
      csz = (n == 9) ? 7 : n - 5;
      d   = 9'($urandom);
      m   = (n >= 8) ? 8'hff : 8'((1 << n) - 1);
      f   = frame(d, n, p, s2, len);
      wr(4'h2, 8'(ds << 1));
      wr(4'h4, 8'(((csz & 3) << 6) | (p << 4) | (s2 << 3)));
      wr(4'h3, 8'(((csz >> 2) << 3) | (d[8] << 2) | 3));
      wr(4'h5, d[7:0]);
      usg_peer_i.grab(len, bc, g);
      chk(g, f);
      repeat (bc) @(posedge clock);
      // second stop low must pass, first stop low must flag
      if (t == 3) f[len - 1] = 1'b0;
      if (t == 4) f[len - 1 - s2] = 1'b0;
      usg_peer_i.send(f, len, bc);
      repeat (2 * bc) @(posedge clock);
      rd(4'h7, v);
      chk(v & 8'hfc, (t == 4) ? 13'h00f0 : 13'h00e0);
      rd(4'h6, v);
      if (n == 9) chk(v[0], d[8]);
      rd(4'h5, v);
      chk(v & m, d[7:0] & m);
      rd(4'h7, v);
      chk(v[7], 1'b0);
      // a low second stop looks like a new start: drain that all-ones word
      if (t == 3) begin
        repeat (len * bc) @(posedge clock);
        rd(4'h5, v);
        chk(v & m, m);
      end
      $display("test %0d done", t);
    end
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h02);
    wr(4'h4, 8'(8'hc3 | ($urandom_range(1) << 2)));
    @(negedge clock);
    chk(ck_oe_n, 1'b0);
    wr(4'h5, 8'($urandom));
    // the first toggle seen may be the idle-level alignment one
    for (int r = 0; r < 3; r++) begin
      c0 = ck_out;
      k  = 0;
      while (ck_out === c0 && k < 200) begin
        @(negedge clock);
        k++;
      end
    end
    chk(k, 13'h0003);
    repeat (80) @(posedge clock);
    $display("test 6 done");
    // sync slave: peer runs the transfer clock, eight bits, no parity
    wr(4'h3, 8'h03);
    wr(4'h4, 8'hc1);
    @(negedge clock);
    chk(ck_oe_n, 1'b1);
    d = 9'($urandom);
    f = frame(d, 8, 0, 0, len);
    wr(4'h5, d[7:0]);
    usg_peer_i.clock_in(len, 8, g);
    chk(g, f);
    $display("test 7 done");
    finish_test();
  end
endmodule // tb_usart_clock_gen_and_framing
